// *** verilog/tlb_match_pkg.sv ***
// shared types and constants for the broadcast invalidation matching tlb
package tlb_match_pkg;

	// =========================================================================
	// widths
	localparam int VA_W = 36; // virtual page number bits held per entry
	localparam int TAG_W = 16; // stored asid and vmid tag width
	localparam int NARROW_W = 8; // low bits compared by a narrow implementation
	localparam int WILDCARD_W = 4; // width of the vmid wildcard field
	localparam logic [TAG_W-1:0] TAG_ZERO = 16'h0000;
	localparam logic [TAG_W-1:0] TAG_ONES = 16'hFFFF;

	// =========================================================================
	// stream regimes and invalidation operations
	typedef enum logic [2:0] {
		RG_NS_EL1,
		RG_SECURE,
		RG_EL2,
		RG_EL2_HOST,
		RG_EL3
	} stream_regime_t;

	typedef enum logic [2:0] {
		OP_ALL,
		OP_VA_ASID,
		OP_VA_ALL_ASID,
		OP_ASID,
		OP_VMID_ALL
	} tlb_invalidate_op_t;

	// =========================================================================
	// carriers
	typedef struct packed {
		logic valid;
		stream_regime_t regime;
		logic global;
		logic asid_sharing_set;
		logic [TAG_W-1:0] asid;
		logic [TAG_W-1:0] vmid;
		logic [VA_W-1:0] va;
	} entry_t;

	typedef struct packed {
		stream_regime_t regime;
		logic asid_sharing_set;
		logic context_table_format_64;
		logic stage2_table_format_64;
		logic [TAG_W-1:0] asid;
		logic [TAG_W-1:0] vmid;
		logic [VA_W-1:0] va;
	} lookup_req_t;

	typedef struct packed {
		stream_regime_t regime;
		logic secure;
		logic global;
		logic asid_sharing_set;
		logic context_table_format_64;
		logic stage2_table_format_64;
		logic [TAG_W-1:0] asid;
		logic [TAG_W-1:0] vmid;
		logic [VA_W-1:0] va;
	} insert_req_t;

	typedef struct packed {
		logic broadcast;
		tlb_invalidate_op_t op;
		stream_regime_t regime;
		logic origin_el3_64;
		logic msg_64;
		logic [TAG_W-1:0] asid;
		logic [TAG_W-1:0] vmid;
		logic [VA_W-1:0] va;
	} inval_req_t;

endpackage : tlb_match_pkg

// *** verilog/bcast_tlb_match.sv ***
// tlb array with lookup, insertion and broadcast or command invalidation matching
`timescale 1ns/1ps
`default_nettype none

// Operation
// - enabled broadcast removes fully matching entries
// - 32-bit-top secure invalidate spares el3 entries
// - 64-bit-top secure el1 invalidate spares el3
// - 64-bit el3 invalidate spares secure entries
// - report asid and vmid widths as capabilities
// - wide tags compare all sixteen bits
// - narrow tags compare low eight bits only
// - asid width ignores context table format
// - vmid width ignores stage 2 format
// - host regime needs non-secure, hyp, enable
// - host enable on: asid tagged and compared
// - host enable off: el2 asid ignored
// - accept four el2 scoped invalidate operations
// - host broadcasts may spare plain el2 entries
// - plain el2 broadcasts may spare host entries
// - el2 address commands follow host enable
// - wildcard ignores low vmid bits on invalidate
// - wildcard applies to broadcasts and commands
// - lookups compare the full vmid of non-secure el1 entries
// - global entries need same regime and set
module bcast_tlb_match import tlb_match_pkg::*; #(
	parameter int ENTRIES = 8, // number of tlb entries
	parameter bit WIDE_ASID = 1'b1, // 16-bit asid implementation
	parameter bit WIDE_VMID = 1'b1, // 16-bit vmid implementation
	parameter bit HYP = 1'b1 // hypervisor support present
) (
	input wire logic CLK, // 50 MHz device clock
	input wire logic NRST, // synchronous reset, active low
	output logic WIDE_ASID_SUPPORTED, // capability: 16-bit asid
	output logic WIDE_VMID_SUPPORTED, // capability: 16-bit vmid
	output logic HYP_SUPPORTED, // capability: hypervisor
	input wire logic HOST_EXTENSION_ENABLE, // el2 host regime control
	input wire logic BCAST_ENABLE, // broadcast participation enable
	input wire logic [WILDCARD_W-1:0] VMID_WILDCARD_BITS, // low vmid bits ignored on invalidate
	input wire logic LKP_VALID, // lookup request strobe
	input wire tlb_match_pkg::lookup_req_t LKP_REQ, // lookup request fields
	output logic LKP_DONE, // lookup answer strobe
	output logic LKP_HIT, // lookup found an entry
	output logic [$clog2(ENTRIES)-1:0] LKP_INDEX, // hitting entry index
	input wire logic INS_VALID, // insertion request strobe
	input wire tlb_match_pkg::insert_req_t INS_REQ, // insertion fields
	output logic INS_DONE, // insertion answer strobe
	output logic INS_ERROR, // insertion refused
	input wire logic INV_VALID, // invalidation request strobe
	input wire tlb_match_pkg::inval_req_t INV_REQ, // invalidation fields
	output logic INV_DONE, // invalidation complete strobe
	output logic [ENTRIES-1:0] INV_REMOVED // entries removed by it
);
	import tlb_match_pkg::*;

	localparam int IDX_W = $clog2(ENTRIES);
	localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(ENTRIES - 1);

	typedef struct packed {
		entry_t [ENTRIES-1:0] ent;
		logic [IDX_W-1:0] victim;
		logic lkp_done;
		logic lkp_hit;
		logic [IDX_W-1:0] lkp_idx;
		logic ins_done;
		logic ins_err;
		logic inv_done;
		logic [ENTRIES-1:0] inv_removed;
	} state_t;

	state_t st;
	state_t next_st;

	// =========================================================================
	// tag helpers
	// a narrow build stores the low byte only, so upper garbage never sticks
	function automatic logic [TAG_W-1:0] store_tag(input logic [TAG_W-1:0] v, input logic wide);
		store_tag = wide ? v : {{(TAG_W-NARROW_W){1'b0}}, v[NARROW_W-1:0]};
	endfunction : store_tag

	// nonzero upper bits are allowed to match a narrow build, which saves a comparator
	function automatic logic tag_eq(input logic [TAG_W-1:0] a, input logic [TAG_W-1:0] b,
			input logic wide);
		tag_eq = wide ? (a == b) : (a[NARROW_W-1:0] == b[NARROW_W-1:0]);
	endfunction : tag_eq

	function automatic logic has_asid(input stream_regime_t r);
		has_asid = (r == RG_NS_EL1) || (r == RG_SECURE) || (r == RG_EL2_HOST);
	endfunction : has_asid

	// =========================================================================
	// invalidation matching, one comparator per entry
	stream_regime_t inv_scope;
	logic [TAG_W-1:0] vmid_mask;
	logic inv_take;
	logic [ENTRIES-1:0] inv_hit;

	always_comb begin
		inv_scope = INV_REQ.regime;
		// commands aimed at el2 retarget with the enable; broadcasts keep their scope
		if (!INV_REQ.broadcast && (INV_REQ.regime == RG_EL2 || INV_REQ.regime == RG_EL2_HOST)) begin
			inv_scope = HOST_EXTENSION_ENABLE ? RG_EL2_HOST : RG_EL2;
		end
		vmid_mask = TAG_ONES << VMID_WILDCARD_BITS;
		inv_take = INV_VALID && (BCAST_ENABLE || !INV_REQ.broadcast);
	end

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_inv
			entry_t e;
			logic rg_ok, asid_ok, vmid_ok, va_ok;
			assign e = st.ent[gi];
			// exact regime equality spares el3 from secure scopes and secure from el3
			assign rg_ok = (INV_REQ.op == OP_VMID_ALL) ? (e.regime == RG_NS_EL1)
				: (e.regime == inv_scope);
			assign asid_ok = !has_asid(e.regime)
				|| !(INV_REQ.op == OP_VA_ASID || INV_REQ.op == OP_ASID)
				|| (e.global ? (INV_REQ.op == OP_VA_ASID)
				: tag_eq(INV_REQ.asid, e.asid, WIDE_ASID));
			assign vmid_ok = (e.regime != RG_NS_EL1)
				|| tag_eq(INV_REQ.vmid & vmid_mask, e.vmid & vmid_mask, WIDE_VMID);
			assign va_ok = !(INV_REQ.op == OP_VA_ASID || INV_REQ.op == OP_VA_ALL_ASID)
				|| (INV_REQ.va == e.va);
			assign inv_hit[gi] = inv_take && e.valid && rg_ok && asid_ok && vmid_ok && va_ok;
		end
	endgenerate

	// =========================================================================
	// lookup matching: full vmid for non-secure el1 entries, asid per entry regime and global bit
	logic [ENTRIES-1:0] lkp_match;

	generate
		for (gi = 0; gi < ENTRIES; gi++) begin : g_lkp
			entry_t e;
			logic asid_ok, glob_ok;
			assign e = st.ent[gi];
			// format bits are deliberately ignored: widths come from the capability only
			assign asid_ok = !has_asid(e.regime) || e.global
				|| tag_eq(LKP_REQ.asid, e.asid, WIDE_ASID);
			assign glob_ok = !e.global || (e.asid_sharing_set == LKP_REQ.asid_sharing_set);
			assign lkp_match[gi] = e.valid && (e.regime == LKP_REQ.regime) && asid_ok && glob_ok
				&& (e.regime != RG_NS_EL1
				|| e.vmid == store_tag(LKP_REQ.vmid, WIDE_VMID))
				&& (e.va == LKP_REQ.va);
		end
	endgenerate

	// =========================================================================
	// next state: invalidate, then insert, then lookup against old contents
	logic ins_bad;

	always_comb begin
		next_st = st;
		ins_bad = (INS_REQ.regime == RG_EL2_HOST)
			&& (INS_REQ.secure || !HYP || !HOST_EXTENSION_ENABLE);
		next_st.inv_done = INV_VALID;
		next_st.inv_removed = inv_hit;
		for (int i = 0; i < ENTRIES; i++) begin
			if (inv_hit[i]) begin
				next_st.ent[i].valid = 1'b0;
			end
		end
		next_st.ins_done = INS_VALID;
		next_st.ins_err = INS_VALID && ins_bad;
		if (INS_VALID && !ins_bad) begin
			next_st.ent[st.victim].valid = 1'b1;
			next_st.ent[st.victim].regime = INS_REQ.regime;
			next_st.ent[st.victim].global = INS_REQ.global && has_asid(INS_REQ.regime);
			next_st.ent[st.victim].asid_sharing_set = INS_REQ.asid_sharing_set;
			// plain el2 and el3 record no meaningful asid
			next_st.ent[st.victim].asid = (has_asid(INS_REQ.regime) && !INS_REQ.global)
				? store_tag(INS_REQ.asid, WIDE_ASID) : TAG_ZERO;
			next_st.ent[st.victim].vmid = store_tag(INS_REQ.vmid, WIDE_VMID);
			next_st.ent[st.victim].va = INS_REQ.va;
			next_st.victim = (st.victim == IDX_LAST) ? '0 : st.victim + 1'b1;
		end
		// lowest index wins if software left duplicates behind
		next_st.lkp_done = LKP_VALID;
		next_st.lkp_hit = LKP_VALID && (|lkp_match);
		next_st.lkp_idx = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (LKP_VALID && lkp_match[i]) begin
				next_st.lkp_idx = IDX_W'(i);
			end
		end
	end

	// state register
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// =========================================================================
	// outputs
	assign WIDE_ASID_SUPPORTED = WIDE_ASID;
	assign WIDE_VMID_SUPPORTED = WIDE_VMID;
	assign HYP_SUPPORTED = HYP;
	assign LKP_DONE = st.lkp_done;
	assign LKP_HIT = st.lkp_hit;
	assign LKP_INDEX = st.lkp_idx;
	assign INS_DONE = st.ins_done;
	assign INS_ERROR = st.ins_err;
	assign INV_DONE = st.inv_done;
	assign INV_REMOVED = st.inv_removed;

	// =========================================================================
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// completion, refusal and disabled participation
	bcast_completes_a: assert property (INV_VALID |=> INV_DONE)
		else $error("invalidation not completed next cycle");
	bcast_off_a: assert property (INV_VALID && INV_REQ.broadcast && !BCAST_ENABLE
		|=> INV_REMOVED == '0)
		else $error("disabled broadcast removed an entry");
	host_refused_a: assert property (INS_VALID && INS_REQ.regime == RG_EL2_HOST
		&& !HOST_EXTENSION_ENABLE |=> INS_DONE && INS_ERROR)
		else $error("host regime insert accepted while disabled");
	host_secure_a: assert property (INS_VALID && INS_REQ.regime == RG_EL2_HOST
		&& INS_REQ.secure |=> INS_DONE && INS_ERROR)
		else $error("secure host regime insert accepted");

	// lookups: a same-cycle insert may overwrite the hit slot, so it is left out
	lookup_vmid_a: assert property (LKP_VALID && !INS_VALID
		&& LKP_REQ.regime == RG_NS_EL1 ##1 LKP_HIT
		|-> st.ent[LKP_INDEX].vmid == store_tag($past(LKP_REQ.vmid), WIDE_VMID))
		else $error("lookup hit with differing vmid");
	host_asid_a: assert property (LKP_VALID && !INS_VALID
		&& LKP_REQ.regime == RG_EL2_HOST ##1 LKP_HIT && !st.ent[LKP_INDEX].global
		|-> tag_eq($past(LKP_REQ.asid), st.ent[LKP_INDEX].asid, WIDE_ASID))
		else $error("host regime hit with wrong asid");
	global_set_a: assert property (LKP_VALID && !INS_VALID
		##1 LKP_HIT && st.ent[LKP_INDEX].global
		|-> st.ent[LKP_INDEX].asid_sharing_set == $past(LKP_REQ.asid_sharing_set))
		else $error("global hit across sharing sets");
	lookup_regime_a: assert property (LKP_VALID && !INS_VALID ##1 LKP_HIT
		|-> st.ent[LKP_INDEX].regime == $past(LKP_REQ.regime))
		else $error("lookup hit an entry of another regime");

	// insertion tagging
	host_store_a: assert property (INS_VALID && INS_REQ.regime == RG_EL2_HOST
		&& HOST_EXTENSION_ENABLE && HYP && WIDE_ASID && !INS_REQ.secure && !INS_REQ.global
		|=> st.ent[$past(st.victim)].asid == $past(INS_REQ.asid))
		else $error("host regime insert lost its asid");
	plain_asid_a: assert property (INS_VALID && INS_REQ.regime == RG_EL2
		|=> st.ent[$past(st.victim)].asid == TAG_ZERO && !st.ent[$past(st.victim)].global)
		else $error("plain el2 entry recorded an asid");
	insert_vmid_a: assert property (INS_VALID && WIDE_VMID && st.victim == '0
		&& INS_REQ.regime != RG_EL2_HOST |=> st.ent[0].vmid == $past(INS_REQ.vmid))
		else $error("inserted vmid not stored in full");

	// regime exemptions on invalidation
	secure_spares_a: assert property (INV_VALID && INV_REQ.regime == RG_SECURE
		&& st.ent[0].regime == RG_EL3 |=> !INV_REMOVED[0])
		else $error("secure scope removed an el3 entry");
	el3_spares_a: assert property (INV_VALID && INV_REQ.regime == RG_EL3
		&& st.ent[ENTRIES-1].regime == RG_SECURE |=> !INV_REMOVED[ENTRIES-1])
		else $error("el3 scope removed a secure entry");
	host_spares_a: assert property (INV_VALID && INV_REQ.broadcast
		&& INV_REQ.regime == RG_EL2_HOST && st.ent[ENTRIES-2].regime == RG_EL2
		|=> !INV_REMOVED[ENTRIES-2])
		else $error("host broadcast removed a plain el2 entry");
	plain_spares_a: assert property (INV_VALID && INV_REQ.broadcast
		&& INV_REQ.regime == RG_EL2 && st.ent[ENTRIES/2].regime == RG_EL2_HOST
		|=> !INV_REMOVED[ENTRIES/2])
		else $error("plain el2 broadcast removed a host entry");

	// tag and wildcard matching on invalidation
	asid_op_tag_a: assert property (INV_VALID && INV_REQ.op == OP_ASID ##1 INV_REMOVED[0]
		|-> tag_eq($past(INV_REQ.asid), $past(st.ent[0].asid), WIDE_ASID))
		else $error("asid invalidate removed a different asid");
	asid_op_global_a: assert property (INV_VALID && INV_REQ.op == OP_ASID
		&& st.ent[ENTRIES-3].global |=> !INV_REMOVED[ENTRIES-3])
		else $error("asid invalidate removed a global entry");
	wildcard_off_a: assert property (INV_VALID && VMID_WILDCARD_BITS == '0 && WIDE_VMID
		&& st.ent[0].regime == RG_NS_EL1 && INV_REQ.vmid != st.ent[0].vmid
		|=> !INV_REMOVED[0])
		else $error("exact vmid invalidate hit another vmid");
	removed_gone_a: assert property (INV_VALID ##1 INV_REMOVED[0]
		|-> !st.ent[0].valid || $past(INS_VALID))
		else $error("removed entry still valid");

	// main scenarios
	hit_cov: cover property (INS_VALID ##1 LKP_VALID ##1 LKP_HIT);
	wild_cov: cover property (INV_VALID && VMID_WILDCARD_BITS != '0 ##1 INV_REMOVED != '0);
	host_cov: cover property (INV_VALID && INV_REQ.regime == RG_EL2_HOST ##1 INV_REMOVED != '0);
	host_ins_cov: cover property (INS_VALID && INS_REQ.regime == RG_EL2_HOST ##1 INS_ERROR);
	cmd_cov: cover property (INV_VALID && !INV_REQ.broadcast ##1 INV_REMOVED != '0);

endmodule : bcast_tlb_match

`default_nettype wire

// *** verif/bcast_origin.sv ***
// processor side model that issues broadcast invalidations and commands
`timescale 1ns/1ps
`default_nettype none
module bcast_origin (
	input wire logic CLK, // device clock
	output logic INV_VALID, // invalidation strobe
	output var tlb_match_pkg::inval_req_t INV_REQ // invalidation fields
);
	import tlb_match_pkg::*;
	// =========================================
	// idle until a request is sent
	initial begin
		INV_VALID = 1'b0;
		INV_REQ = '0;
	end
	// one request, after a gap of zero to three cycles
	task automatic send(input logic bc, input tlb_invalidate_op_t op, input stream_regime_t rg,
		input logic [15:0] as, input logic [15:0] vm, input logic [35:0] ad, input logic nw,
		input logic [1:0] gap);
		repeat (gap) @(posedge CLK);
		@(posedge CLK);
		#1;
		INV_VALID = 1'b1;
		// a narrow originator owns eight bits, the system widens them with zeros
		INV_REQ = '{bc, op, rg, 1'b1, 1'b1, nw ? {8'h00, as[7:0]} : as,
			nw ? {8'h00, vm[7:0]} : vm, ad};
		@(posedge CLK);
		#1;
		INV_VALID = 1'b0;
		// released fields must not look like the last request
		INV_REQ = inval_req_t'(~INV_REQ);
	endtask : send
endmodule : bcast_origin
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the broadcast invalidation matching tlb
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tlb_match_pkg::*;
	// =========================================
	// signals and instances
	logic clk, nrst, hen, ben, lv, insv, ld, lh, idn, ie, vd, wa, wv, hs, iv, lset;
	logic [3:0] vmid_wildcard_bits;
	logic [2:0] li;
	logic [7:0] rm;
	lookup_req_t lq;
	insert_req_t iq;
	inval_req_t vq;
	int n_errors, check_count;
	logic [31:0] seed;
	logic [15:0] ta[4], tv[4];
	logic [35:0] tx[4];
	bcast_tlb_match bcast_tlb_match_inst (.CLK(clk), .NRST(nrst), .WIDE_ASID_SUPPORTED(wa),
		.WIDE_VMID_SUPPORTED(wv), .HYP_SUPPORTED(hs), .HOST_EXTENSION_ENABLE(hen),
		.BCAST_ENABLE(ben), .VMID_WILDCARD_BITS(vmid_wildcard_bits), .LKP_VALID(lv), .LKP_REQ(lq),
		.LKP_DONE(ld), .LKP_HIT(lh), .LKP_INDEX(li), .INS_VALID(insv), .INS_REQ(iq),
		.INS_DONE(idn), .INS_ERROR(ie), .INV_VALID(iv), .INV_REQ(vq), .INV_DONE(vd),
		.INV_REMOVED(rm));
	bcast_origin bcast_origin_inst (.CLK(clk), .INV_VALID(iv), .INV_REQ(vq));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// =========================================
	// helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic chk(input string nm, input logic [35:0] s, input logic [35:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task print_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : print_verdict
	// format bits stay at the 32-bit table setting: tag widths must not care
	task automatic ins(input stream_regime_t r, input logic s, input logic g,
		input logic [15:0] as, input logic [15:0] vm, input logic [35:0] ad, input logic er);
		@(posedge clk);
		#1;
		insv = 1'b1;
		iq = '{r, s, g, 1'b0, 1'b0, 1'b0, as, vm, ad};
		@(posedge clk);
		#1;
		insv = 1'b0;
		chk("ins_done", idn, 1);
		chk("ins_error", ie, er);
	endtask : ins
	task automatic lk(input stream_regime_t r, input logic [15:0] as, input logic [15:0] vm,
		input logic [35:0] ad, input logic h, input logic [2:0] ix);
		@(posedge clk);
		#1;
		lv = 1'b1;
		lq = '{r, lset, 1'b0, 1'b0, as, vm, ad};
		@(posedge clk);
		#1;
		lv = 1'b0;
		chk("lkp_done", ld, 1);
		chk("lkp_hit", lh, h);
		chk("lkp_index", li, ix);
	endtask : lk
	task automatic inv(input logic bc, input tlb_invalidate_op_t op, input stream_regime_t r,
		input logic [15:0] as, input logic [15:0] vm, input logic [35:0] ad, input logic nw,
		input logic [7:0] ex);
		bcast_origin_inst.send(bc, op, r, as, vm, ad, nw, 2'(rnd()));
		chk("inv_done", vd, 1);
		chk("inv_removed", rm, ex);
	endtask : inv
	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	// =========================================
	// main sequence
	initial begin
		seed = 32'd47930;
		n_errors = 0;
		check_count = 0;
		{nrst, hen, ben, lv, insv, lset, vmid_wildcard_bits} = '0;
		lq = '0;
		iq = '0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk("cap_asid", wa, 1);
		chk("cap_vmid", wv, 1);
		chk("cap_hyp", hs, 1);
		vmid_wildcard_bits = 4'h1;
		// random entries; lookups never use the wildcard
		for (int i = 0; i < 4; i++) begin
			ta[i] = 16'(rnd()) & 16'h00FF;
			tv[i] = 16'(rnd()) & 16'h00FF;
			tx[i] = 36'(rnd());
			ins(RG_NS_EL1, 1'b0, 1'b0, ta[i], tv[i], tx[i], 1'b0);
			lk(RG_NS_EL1, ta[i], tv[i], tx[i], 1'b1, 3'(i));
			lk(RG_NS_EL1, ta[i], tv[i] ^ 16'h0001, tx[i], 1'b0, 3'h0);
			lk(RG_NS_EL1, ta[i] ^ 16'h0100, tv[i], tx[i], 1'b0, 3'h0);
		end
		inv(1, OP_ALL, RG_NS_EL1, ta[0], tv[0], tx[0], 0, 8'h00);
		ben = 1'b1;
		vmid_wildcard_bits = 4'h0;
		inv(1, OP_VA_ASID, RG_NS_EL1, ta[0], tv[0] ^ 16'h0001, tx[0], 0, 8'h00);
		inv(1, OP_VA_ASID, RG_NS_EL1, ta[0] ^ 16'h8000, tv[0], tx[0], 0, 8'h00);
		vmid_wildcard_bits = 4'h1;
		inv(1, OP_VA_ASID, RG_NS_EL1, ta[2], tv[2] ^ 16'h0001, tx[2], 0, 8'h04);
		inv(0, OP_VA_ASID, RG_NS_EL1, ta[1], tv[1] ^ 16'h0001, tx[1], 0, 8'h02);
		inv(1, OP_ASID, RG_NS_EL1, {8'hA5, ta[0][7:0]}, tv[0], 36'h0, 1, 8'h01);
		inv(1, OP_VMID_ALL, RG_NS_EL1, 16'h0000, tv[3], 36'h0, 0, 8'h08);
		// host regime: refused, then asid tagged and globals exempt
		ins(RG_EL2_HOST, 1'b0, 1'b0, 16'h1234, 16'h0000, 36'h100, 1'b1);
		hen = 1'b1;
		ins(RG_EL2_HOST, 1'b1, 1'b0, 16'h1234, 16'h0000, 36'h100, 1'b1);
		ins(RG_EL2_HOST, 1'b0, 1'b0, 16'h1234, 16'h0000, 36'h100, 1'b0);
		ins(RG_EL2_HOST, 1'b0, 1'b1, 16'h1234, 16'h0000, 36'h200, 1'b0);
		lk(RG_EL2_HOST, 16'h1235, 16'h0000, 36'h100, 1'b0, 3'h0);
		lk(RG_EL2_HOST, 16'h1234, 16'h0000, 36'h100, 1'b1, 3'h4);
		lk(RG_EL2_HOST, 16'h4321, 16'h0000, 36'h200, 1'b1, 3'h5);
		// a global entry stays inside the sharing set that created it
		lset = 1'b1;
		lk(RG_EL2_HOST, 16'h4321, 16'h0000, 36'h200, 1'b0, 3'h0);
		lset = 1'b0;
		inv(1, OP_ALL, RG_EL2, 16'h0000, 16'h0000, 36'h0, 0, 8'h00);
		inv(1, OP_ASID, RG_EL2_HOST, 16'h1234, 16'h0000, 36'h0, 0, 8'h10);
		inv(1, OP_VA_ALL_ASID, RG_EL2_HOST, 16'h0000, 16'h0000, 36'h200, 0, 8'h20);
		// el2 entries are gone, so the control bit may change
		hen = 1'b0;
		ins(RG_EL2, 1'b0, 1'b0, 16'h7777, 16'h0000, 36'h300, 1'b0);
		lk(RG_EL2, 16'h0001, 16'h0000, 36'h300, 1'b1, 3'h6);
		inv(1, OP_ALL, RG_EL2_HOST, 16'h0000, 16'h0000, 36'h0, 0, 8'h00);
		inv(1, OP_ALL, RG_EL2, 16'h0000, 16'h0000, 36'h0, 0, 8'h40);
		// the secure scope spares the el3 entry, then the el3 scope removes it
		ins(RG_SECURE, 1'b1, 1'b0, 16'h0042, 16'h0000, 36'h400, 1'b0);
		ins(RG_EL3, 1'b1, 1'b0, 16'h0000, 16'h0000, 36'h400, 1'b0);
		inv(1, OP_ALL, RG_SECURE, 16'h0000, 16'h0000, 36'h0, 0, 8'h80);
		inv(1, OP_ALL, RG_EL3, 16'h0000, 16'h0000, 36'h0, 0, 8'h01);
		// an el2 address command follows the enable, which is off here
		ins(RG_EL2, 1'b0, 1'b0, 16'h0000, 16'h0000, 36'h500, 1'b0);
		inv(0, OP_VA_ALL_ASID, RG_EL2_HOST, 16'h0000, 16'h0000, 36'h500, 0, 8'h02);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
